// >>> common/hppc_pkg.sv
// ****************************************************************
// shared constants for the framed serial port pin control
// ****************************************************************
package hppc_pkg;

  // ****************************************************************
  // register bus
  // ****************************************************************
  localparam int          ADDR_W   = 8;      // byte address width
  localparam int          DATA_W   = 32;     // bus data width
  localparam logic [7:0]  OFS_CTRL = 8'h00;  // mode and direction bits
  localparam logic [7:0]  OFS_DIV  = 8'h04;  // generated clock half period
  localparam logic [7:0]  OFS_TXD  = 8'h08;  // word sent every frame
  localparam logic [7:0]  OFS_RXD  = 8'h0c;  // last word received
  localparam logic [7:0]  OFS_STAT = 8'h10;  // live status

  // ****************************************************************
  // control field positions
  // ****************************************************************
  localparam int CTRL_W      = 7;  // implemented control bits
  localparam int B_EN        = 0;  // port enable
  localparam int B_TXFS_OUT  = 1;  // tx frame sync drives pin
  localparam int B_TXCLK_OUT = 2;  // tx line clock drives pin
  localparam int B_RXFS_OUT  = 3;  // rx frame sync drives pin
  localparam int B_RXCLK_OUT = 4;  // rx line clock drives pin
  localparam int B_TX_FALL   = 5;  // launch on falling edge
  localparam int B_RX_FALL   = 6;  // capture on falling edge
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;  // all pins inputs

  // ****************************************************************
  // synchronised pin indexes
  // ****************************************************************
  localparam int PIN_N   = 5;
  localparam int P_TXCLK = 0;
  localparam int P_TXFS  = 1;
  localparam int P_RXCLK = 2;
  localparam int P_RXFS  = 3;
  localparam int P_RXD   = 4;

  // ****************************************************************
  // timing: line clock range against the system clock
  // ****************************************************************
  localparam longint CLK_HZ      = 10_000_000;  // system clock
  localparam longint LINE_MIN_HZ = 512_000;     // slowest line clock
  localparam longint LINE_MAX_HZ = 8_192_000;   // fastest line clock
  localparam int     DIV_W       = 8;
  // longest half period keeps the clock at or above the minimum
  localparam longint DIV_MAX_L   = CLK_HZ / (2 * LINE_MIN_HZ);
  // shortest half period keeps it at or below the maximum
  localparam longint DIV_MIN_C   =
    (CLK_HZ + 2 * LINE_MAX_HZ - 1) / (2 * LINE_MAX_HZ);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(DIV_MAX_L);
  localparam logic [DIV_W-1:0] DIV_MIN =
    (DIV_MIN_C < 1) ? DIV_W'(1) : DIV_W'(DIV_MIN_C);
  localparam logic [DIV_W-1:0] DIV_RST = DIV_MAX;

endpackage

// >>> design/hppc_pin_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// two-flop synchroniser with edge detect, one lane per pin
// ****************************************************************
module hppc_pin_sync
  #(parameter int W = 1)
  (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // raw pins
    input  wire logic [W-1:0] pin_in,
    // clean level and one-cycle edge pulses
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
  );

  logic [W-1:0] meta_r;   // first stage, read only by stage two
  logic [W-1:0] sync_r;   // second stage, safe level
  logic [W-1:0] prev_r;   // delayed copy for edges
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;
  logic [W-1:0] prev_nxt;

  // next values: plain shift, pins idle high like the pull-ups
  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // edges look at stages two and three only
  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;

endmodule

// >>> design/hppc_top.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module hppc_top
  import hppc_pkg::*;
  #(parameter int FRAME_BITS = 8)
  (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [DATA_W-1:0] reg_rdata,
    // transmit pins
    input  wire logic              tx_frame_sync_i,
    output logic                   tx_frame_sync_o,
    output logic                   tx_frame_sync_oe,
    input  wire logic              tx_line_clock_i,
    output logic                   tx_line_clock_o,
    output logic                   tx_line_clock_oe,
    output logic                   tx_serial_out_o,
    output logic                   tx_serial_out_oe,
    // receive pins
    input  wire logic              rx_frame_sync_i,
    output logic                   rx_frame_sync_o,
    output logic                   rx_frame_sync_oe,
    input  wire logic              rx_line_clock_i,
    output logic                   rx_line_clock_o,
    output logic                   rx_line_clock_oe,
    input  wire logic              rx_serial_in
  );

  localparam int CW = $clog2(FRAME_BITS + 1);  // bit counter width
  localparam logic [CW-1:0] LAST = CW'(FRAME_BITS - 1);
  localparam logic [CW-1:0] FULL = CW'(FRAME_BITS);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // keep a written half period inside the legal line clock range
  function automatic logic [DIV_W-1:0] clamp_div(logic [DIV_W-1:0] v);
    if (v < DIV_MIN)
      return DIV_MIN;
    else if (v > DIV_MAX)
      return DIV_MAX;
    return v;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [PIN_N-1:0] s_lvl;   // clean pin levels
  logic [PIN_N-1:0] s_rise;  // pin rising edges
  logic [PIN_N-1:0] s_fall;  // pin falling edges

  hppc_pin_sync #(.W(PIN_N)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({rx_serial_in, rx_frame_sync_i, rx_line_clock_i,
               tx_frame_sync_i, tx_line_clock_i}),
    .level   (s_lvl),
    .rise    (s_rise),
    .fall    (s_fall)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  logic [CTRL_W-1:0]     ctrl_r, ctrl_nxt;      // mode bits
  logic [DIV_W-1:0]      div_r, div_nxt;        // half period
  logic [FRAME_BITS-1:0] txd_r, txd_nxt;        // word to send
  logic [FRAME_BITS-1:0] rxw_r, rxw_nxt;        // word received
  logic                  rxv_r, rxv_nxt;        // new word flag
  logic [DATA_W-1:0]     rdata_r, rdata_nxt;    // read answer
  logic [DIV_W-1:0]      gcnt_r [2];            // generator counts
  logic [DIV_W-1:0]      gcnt_nxt [2];
  logic [1:0]            glvl_r, glvl_nxt;      // generated clocks
  logic [1:0]            grise, gfall;          // generated edges
  logic [3:0]            oe_r, oe_nxt;          // pin drive enables
  logic [CW-1:0]         tslot_r, tslot_nxt;    // tx frame position
  logic [CW-1:0]         tleft_r, tleft_nxt;    // tx bits still due
  logic [FRAME_BITS-1:0] tsh_r, tsh_nxt;        // tx shifter
  logic                  tbit_r, tbit_nxt;      // bit on the line
  logic                  tfs_r, tfs_nxt;        // tx frame sync out
  logic [CW-1:0]         rslot_r, rslot_nxt;    // rx frame position
  logic                  rfs_r, rfs_nxt;        // rx frame sync out
  logic [CW-1:0]         rcnt_r, rcnt_nxt;      // rx bits gathered
  logic [FRAME_BITS-1:0] rsh_r, rsh_nxt;        // rx shifter
  logic                  tx_launch, rx_cap, rx_launch;
  logic                  tx_start, rx_start;
  logic [FRAME_BITS-1:0] rsh_in;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    div_nxt   = div_r;
    txd_nxt   = txd_r;
    rxw_nxt   = rxw_r;
    rxv_nxt   = rxv_r;
    rdata_nxt = '0;
    glvl_nxt  = glvl_r;
    grise     = 2'b00;
    gfall     = 2'b00;
    tslot_nxt = tslot_r;
    tleft_nxt = tleft_r;
    tsh_nxt   = tsh_r;
    tbit_nxt  = tbit_r;
    tfs_nxt   = tfs_r;
    rslot_nxt = rslot_r;
    rfs_nxt   = rfs_r;
    rcnt_nxt  = rcnt_r;
    rsh_nxt   = rsh_r;
    rsh_in    = '0;
    for (int i = 0; i < 2; i++)
      gcnt_nxt[i] = gcnt_r[i];

    // register writes; direction bits come up as inputs
    if (reg_we)
    begin
      unique case (reg_addr)
        OFS_CTRL: ctrl_nxt = reg_wdata[CTRL_W-1:0];
        OFS_DIV:  div_nxt = clamp_div(reg_wdata[DIV_W-1:0]);
        OFS_TXD:  txd_nxt = reg_wdata[FRAME_BITS-1:0];
        default:  ;  // writes elsewhere are dropped
      endcase
    end

    // register reads; unmapped addresses read zero
    if (reg_re)
    begin
      unique case (reg_addr)
        OFS_CTRL: rdata_nxt = DATA_W'(ctrl_r);
        OFS_DIV:  rdata_nxt = DATA_W'(div_r);
        OFS_TXD:  rdata_nxt = DATA_W'(txd_r);
        OFS_RXD:  rdata_nxt = DATA_W'(rxw_r);
        OFS_STAT: rdata_nxt = DATA_W'({s_lvl[P_RXCLK], s_lvl[P_TXCLK],
                                        rxv_r});
        default:  rdata_nxt = '0;
      endcase
    end
    // reading the word clears its flag; a capture below still wins
    if (reg_re && reg_addr == OFS_RXD)
      rxv_nxt = 1'b0;

    // clock generators: index 0 transmit, 1 receive
    // both share one divider, which keeps the range check in one place
    for (int i = 0; i < 2; i++)
    begin
      if (!ctrl_r[B_EN] || !ctrl_r[i == 0 ? B_TXCLK_OUT : B_RXCLK_OUT])
      begin
        gcnt_nxt[i] = '0;    // parked high, like the pull-up
        glvl_nxt[i] = 1'b1;
      end
      else if (gcnt_r[i] >= div_r - DIV_W'(1))
      begin
        gcnt_nxt[i] = '0;
        glvl_nxt[i] = ~glvl_r[i];
        grise[i]    = ~glvl_r[i];
        gfall[i]    = glvl_r[i];
      end
      else
        gcnt_nxt[i] = gcnt_r[i] + DIV_W'(1);
    end

    // pick the active edges of each line clock
    // a pin clock near the top of the range is undersampled at this
    // system rate; the generated clock never is
    if (ctrl_r[B_TXCLK_OUT])
      tx_launch = ctrl_r[B_TX_FALL] ? gfall[0] : grise[0];
    else
      tx_launch = ctrl_r[B_TX_FALL] ? s_fall[P_TXCLK]
                                    : s_rise[P_TXCLK];
    if (ctrl_r[B_RXCLK_OUT])
    begin
      rx_cap    = ctrl_r[B_RX_FALL] ? gfall[1] : grise[1];
      rx_launch = ctrl_r[B_RX_FALL] ? grise[1] : gfall[1];
    end
    else
    begin
      rx_cap    = ctrl_r[B_RX_FALL] ? s_fall[P_RXCLK]
                                    : s_rise[P_RXCLK];
      rx_launch = ctrl_r[B_RX_FALL] ? s_rise[P_RXCLK]
                                    : s_fall[P_RXCLK];
    end
    tx_launch = tx_launch & ctrl_r[B_EN];
    rx_cap    = rx_cap & ctrl_r[B_EN];
    rx_launch = rx_launch & ctrl_r[B_EN];

    // transmit: frame starts on own slot zero or on the far sync
    tx_start = ctrl_r[B_TXFS_OUT] ? (tslot_r == '0)
                                  : s_lvl[P_TXFS];
    if (!ctrl_r[B_EN])
    begin
      tbit_nxt  = 1'b1;     // idle releases the line
      tfs_nxt   = 1'b0;
      tslot_nxt = '0;
      tleft_nxt = '0;
    end
    else if (tx_launch)
    begin
      tfs_nxt   = (tslot_r == '0);
      tslot_nxt = (tslot_r == LAST) ? '0 : tslot_r + CW'(1);
      if (tx_start)
      begin
        tbit_nxt  = txd_r[FRAME_BITS-1];   // msb first
        tsh_nxt   = {txd_r[FRAME_BITS-2:0], 1'b0};
        tleft_nxt = LAST;
      end
      else if (tleft_r != '0)
      begin
        tbit_nxt  = tsh_r[FRAME_BITS-1];
        tsh_nxt   = {tsh_r[FRAME_BITS-2:0], 1'b0};
        tleft_nxt = tleft_r - CW'(1);
      end
      else
        tbit_nxt = 1'b1;    // between frames the line floats high
    end

    // receive frame sync generation, on the edge opposite capture
    if (!ctrl_r[B_EN])
    begin
      rfs_nxt   = 1'b0;
      rslot_nxt = '0;
      rcnt_nxt  = '0;
    end
    else if (rx_launch)
    begin
      rfs_nxt   = (rslot_r == '0);
      rslot_nxt = (rslot_r == LAST) ? '0 : rslot_r + CW'(1);
    end

    // receive capture: sync marks the first bit of a word
    rx_start = ctrl_r[B_RXFS_OUT] ? rfs_r : s_lvl[P_RXFS];
    if (rx_cap)
    begin
      rsh_in = {rsh_r[FRAME_BITS-2:0], s_lvl[P_RXD]};
      if (rx_start)
      begin
        rsh_nxt  = {{(FRAME_BITS-1){1'b0}}, s_lvl[P_RXD]};
        rcnt_nxt = CW'(1);
      end
      else if (rcnt_r != '0)
      begin
        rsh_nxt  = rsh_in;
        rcnt_nxt = rcnt_r + CW'(1);
      end
      if (!rx_start && rcnt_r == LAST)
      begin
        rxw_nxt  = rsh_in;  // word complete
        rxv_nxt  = 1'b1;    // set wins over a same-cycle read
        rcnt_nxt = '0;
      end
    end

    // pin enables follow the direction bits only while enabled
    oe_nxt = ctrl_r[B_EN] ? {ctrl_r[B_RXCLK_OUT], ctrl_r[B_RXFS_OUT],
                              ctrl_r[B_TXCLK_OUT], ctrl_r[B_TXFS_OUT]}
                          : 4'h0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_r  <= CTRL_RST;
      div_r   <= DIV_RST;
      txd_r   <= '0;
      rxw_r   <= '0;
      rxv_r   <= 1'b0;
      rdata_r <= '0;
      glvl_r  <= 2'b11;
      gcnt_r  <= '{default: '0};
      oe_r    <= 4'h0;
      tslot_r <= '0;
      tleft_r <= '0;
      tsh_r   <= '0;
      tbit_r  <= 1'b1;
      tfs_r   <= 1'b0;
      rslot_r <= '0;
      rfs_r   <= 1'b0;
      rcnt_r  <= '0;
      rsh_r   <= '0;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      div_r   <= div_nxt;
      txd_r   <= txd_nxt;
      rxw_r   <= rxw_nxt;
      rxv_r   <= rxv_nxt;
      rdata_r <= rdata_nxt;
      glvl_r  <= glvl_nxt;
      gcnt_r  <= gcnt_nxt;
      oe_r    <= oe_nxt;
      tslot_r <= tslot_nxt;
      tleft_r <= tleft_nxt;
      tsh_r   <= tsh_nxt;
      tbit_r  <= tbit_nxt;
      tfs_r   <= tfs_nxt;
      rslot_r <= rslot_nxt;
      rfs_r   <= rfs_nxt;
      rcnt_r  <= rcnt_nxt;
      rsh_r   <= rsh_nxt;
    end
  end

  // ****************************************************************
  // outputs, all from flops; tx_serial_out_oe through an inverter
  // ****************************************************************
  assign reg_rdata        = rdata_r;
  assign tx_frame_sync_o  = tfs_r;
  assign tx_frame_sync_oe = oe_r[0];
  assign tx_line_clock_o  = glvl_r[0];
  assign tx_line_clock_oe = oe_r[1];
  assign rx_frame_sync_o  = rfs_r;
  assign rx_frame_sync_oe = oe_r[2];
  assign rx_line_clock_o  = glvl_r[1];
  assign rx_line_clock_oe = oe_r[3];
  // open drain: value is only ever low while driven
  assign tx_serial_out_o  = tbit_r;
  assign tx_serial_out_oe = ~tbit_r;

endmodule

// >>> sim/hppc_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// pin behaviour checks, seen from the top ports only
// ****************************************************************
module hppc_assertions
  import hppc_pkg::*;
  (
    // clock and reset
    input wire logic              clk,
    input wire logic              sys_rst,
    // register writes, shadowed here
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_we,
    // pin outputs
    input wire logic              tx_frame_sync_oe,
    input wire logic              tx_line_clock_o,
    input wire logic              tx_line_clock_oe,
    input wire logic              tx_serial_out_o,
    input wire logic              tx_serial_out_oe,
    input wire logic              rx_frame_sync_oe,
    input wire logic              rx_line_clock_o,
    input wire logic              rx_line_clock_oe
  );
  logic [CTRL_W-1:0] ctl_r, ctl_nxt;   // shadow control word
  logic [1:0]        age_r, age_nxt;   // cycles since a control write
  logic [3:0]        tcnt_r, tcnt_nxt; // tx clock level run length
  logic [3:0]        rcnt_r, rcnt_nxt; // rx clock level run length
  logic              tck_r, rck_r;     // clock levels a cycle ago

  // ****************************************************************
  // helper state
  // ****************************************************************
  // next values; a control write restarts the settling count
  always_comb
  begin
    ctl_nxt = ctl_r;
    age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
    if (reg_we && reg_addr == OFS_CTRL)
    begin
      ctl_nxt = reg_wdata[CTRL_W-1:0];
      age_nxt = 2'h0;
    end
    // run length is zero while the pin is not driven
    tcnt_nxt = (!tx_line_clock_oe || tx_line_clock_o != tck_r)
               ? 4'h0 : tcnt_r + 4'h1;
    rcnt_nxt = (!rx_line_clock_oe || rx_line_clock_o != rck_r)
               ? 4'h0 : rcnt_r + 4'h1;
  end

  // register only
  always_ff @(posedge clk)
  begin
    ctl_r  <= sys_rst ? CTRL_RST : ctl_nxt;
    age_r  <= sys_rst ? 2'h3 : age_nxt;
    tcnt_r <= sys_rst ? 4'h0 : tcnt_nxt;
    rcnt_r <= sys_rst ? 4'h0 : rcnt_nxt;
    tck_r  <= tx_line_clock_o;
    rck_r  <= rx_line_clock_o;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_RST_REL: assert property (@(posedge clk)
    disable iff (sys_rst) $fell(sys_rst) |-> !tx_serial_out_oe &&
    tx_serial_out_o && !tx_line_clock_oe && !rx_line_clock_oe)
    else $error("pins not released after reset");
  AST_TXD_OD: assert property (@(posedge clk)
    disable iff (sys_rst) tx_serial_out_oe |-> !tx_serial_out_o)
    else $error("open drain pin driven for a one");
  AST_TXFS_DIR: assert property (@(posedge clk)
    disable iff (sys_rst) age_r == 2'h3 |->
    tx_frame_sync_oe == (ctl_r[B_EN] && ctl_r[B_TXFS_OUT]))
    else $error("tx frame sync direction wrong");
  AST_RXFS_DIR: assert property (@(posedge clk)
    disable iff (sys_rst) age_r == 2'h3 |->
    rx_frame_sync_oe == (ctl_r[B_EN] && ctl_r[B_RXFS_OUT]))
    else $error("rx frame sync direction wrong");
  AST_TXCLK_DIR: assert property (@(posedge clk)
    disable iff (sys_rst) age_r == 2'h3 |->
    tx_line_clock_oe == (ctl_r[B_EN] && ctl_r[B_TXCLK_OUT]))
    else $error("tx clock direction wrong");
  AST_RXCLK_DIR: assert property (@(posedge clk)
    disable iff (sys_rst) age_r == 2'h3 |->
    rx_line_clock_oe == (ctl_r[B_EN] && ctl_r[B_RXCLK_OUT]))
    else $error("rx clock direction wrong");
  // the three cycles after a control write are not judged
  AST_TXCLK_RNG: assert property (@(posedge clk)
    disable iff (sys_rst) age_r == 2'h3 |-> tcnt_r < DIV_MAX)
    else $error("tx clock slower than allowed");
  AST_RXCLK_RNG: assert property (@(posedge clk)
    disable iff (sys_rst) age_r == 2'h3 |-> rcnt_r < DIV_MAX)
    else $error("rx clock slower than allowed");
  // data and clock move on the same system edge, so the clock level
  // seen beside a data change is the one just after the launch edge
  AST_TX_EDGE: assert property (@(posedge clk)
    disable iff (sys_rst) $changed(tx_serial_out_oe) && age_r == 2'h3
    && ctl_r[B_EN] && ctl_r[B_TXCLK_OUT] |->
    tx_line_clock_o != ctl_r[B_TX_FALL])
    else $error("tx data launched on the wrong edge");
endmodule

bind hppc_top hppc_assertions u_chk (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_we, .tx_frame_sync_oe, .tx_line_clock_o,
  .tx_line_clock_oe, .tx_serial_out_o, .tx_serial_out_oe,
  .rx_frame_sync_oe, .rx_line_clock_o, .rx_line_clock_oe);

// >>> sim/hppc_far_end.sv
`timescale 1ns/1ps
// ****************************************************************
// far end line device: feeds rx, listens on tx
// ****************************************************************
module hppc_far_end
  #(parameter int FRAME_BITS = 8)
  (
    // transmit lines as seen on the board
    input wire logic tx_clk,
    input wire logic tx_fs,
    input wire logic tx_dat,
    input wire logic tx_fall,
    // receive lines driven from here
    output logic     rx_clk,
    output logic     rx_fs,
    output logic     rx_dat
  );
  logic [FRAME_BITS-1:0] tx_sh;   // bits gathered so far
  logic [FRAME_BITS-1:0] tx_word; // last whole word
  int                    tx_bits; // bits in the current word
  int                    tx_cnt;  // whole words seen

  // idle: clock stands still, lines pulled up
  initial
  begin
    rx_clk  = 1'b1;
    rx_fs   = 1'b1;
    rx_dat  = 1'b1;
    tx_sh   = '0;
    tx_word = '0;
    tx_bits = FRAME_BITS;
    tx_cnt  = 0;
  end

  // sample on the edge opposite the launch edge
  always @(tx_clk)
  begin
    if (tx_clk === tx_fall)
    begin
      // sync marks the first bit of a word
      if (tx_fs === 1'b1)
        tx_bits = 0;
      if (tx_bits < FRAME_BITS)
      begin
        tx_sh = {tx_sh[FRAME_BITS-2:0], tx_dat};
        tx_bits++;
        if (tx_bits == FRAME_BITS)
        begin
          tx_word = tx_sh;
          tx_cnt++;
        end
      end
    end
  end

  // one word, msb first, clock runs only inside the frame
  task automatic send(input logic [FRAME_BITS-1:0] w, input logic cf);
    #13;
    for (int i = FRAME_BITS - 1; i >= 0; i--)
    begin
      rx_clk = cf;                     // launch edge
      rx_dat = w[i];
      rx_fs  = (i == FRAME_BITS - 1);
      #400;
      rx_clk = !cf;                    // capture edge, 400 ns after launch
      #400;
    end
    rx_clk = 1'b1;
    rx_fs  = 1'b1;
    rx_dat = 1'b1;
  endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// bench for the framed serial port pin control
// ****************************************************************
module tb_top;
  import hppc_pkg::*;
  localparam int FB   = 8;      // bits per word
  localparam int CEIL = 20000;  // cycle ceiling, tests need ~500
  logic              clk, sys_rst, reg_we, reg_re, tx_fall;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic              tfs_o, tfs_oe, tck_o, tck_oe, tsd_o, tsd_oe;
  logic              rfs_o, rfs_oe, rck_o, rck_oe, f_rck, f_rfs, f_rsd;
  logic [FB-1:0]     w;
  int                fails, n_tests, cyc, k, n;
  // board lines, pull-up wherever nobody drives
  wire tck_w = (tck_oe === 1'b1) ? tck_o : 1'b1;
  wire tfs_w = (tfs_oe === 1'b1) ? tfs_o : 1'b1;
  wire tsd_w = (tsd_oe !== 1'b1);  // open drain
  wire rck_w = (rck_oe === 1'b1) ? rck_o : f_rck;
  wire rfs_w = (rfs_oe === 1'b1) ? rfs_o : f_rfs;

  hppc_top #(.FRAME_BITS(FB)) u_dut (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .tx_frame_sync_i(tfs_w), .tx_frame_sync_o(tfs_o),
    .tx_frame_sync_oe(tfs_oe), .tx_line_clock_i(tck_w),
    .tx_line_clock_o(tck_o), .tx_line_clock_oe(tck_oe),
    .tx_serial_out_o(tsd_o), .tx_serial_out_oe(tsd_oe),
    .rx_frame_sync_i(rfs_w), .rx_frame_sync_o(rfs_o),
    .rx_frame_sync_oe(rfs_oe), .rx_line_clock_i(rck_w),
    .rx_line_clock_o(rck_o), .rx_line_clock_oe(rck_oe),
    .rx_serial_in(f_rsd));
  hppc_far_end #(.FRAME_BITS(FB)) u_far (.tx_clk(tck_w),
    .tx_fs(tfs_w), .tx_dat(tsd_w), .tx_fall(tx_fall),
    .rx_clk(f_rck), .rx_fs(f_rfs), .rx_dat(f_rsd));

  // ****************************************************************
  // bus tasks and checks
  // ****************************************************************
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task chk(input string nm, input logic [DATA_W-1:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == CEIL)
    begin
      fails++;
      results();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {fails, n_tests, cyc} = '0;
    {reg_we, reg_re, reg_addr, reg_wdata, tx_fall} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // reset: every pin an input, tx data released
    rd(OFS_CTRL, d);
    chk("ctrl", 32'h0, d);
    rd(OFS_DIV, d);
    chk("div", 32'(DIV_RST), d);
    chk("oe", 32'h0, {rck_oe, rfs_oe, tck_oe, tfs_oe, tsd_oe});
    // each direction bit turns its own pin only
    for (int i = 1; i <= 4; i++)
    begin
      wr(OFS_CTRL, 32'h1 | (32'h1 << i));
      repeat (5) @(posedge clk);
      chk("dir", 32'h1 << (i - 1), {rck_oe, rfs_oe, tck_oe, tfs_oe});
    end
    // clock divider clamps and an unmapped place
    wr(OFS_DIV, 32'hff);
    rd(OFS_DIV, d);
    chk("div max", 32'(DIV_MAX), d);
    wr(OFS_DIV, 32'h0);
    rd(OFS_DIV, d);
    chk("div min", 32'(DIV_MIN), d);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    $display("test registers done");
    // transmit on each launch edge, own clock and sync
    wr(OFS_DIV, 32'h4);
    for (int e = 0; e < 2; e++)
    begin
      w = e ? 8'h3c : 8'ha5;
      tx_fall <= e[0];
      wr(OFS_TXD, 32'(w));
      wr(OFS_CTRL, 32'h7 | (32'(e) << B_TX_FALL));
      n = u_far.tx_cnt;
      for (k = 0; k < 2000 && u_far.tx_cnt < n + 2; k++)
        @(posedge clk);
      chk("tx word", 32'(w), 32'(u_far.tx_word));
      wr(OFS_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      chk("tx idle", 32'h0, 32'(tsd_oe));
      $display("test tx edge %0d done", e);
    end
    // receive on each capture edge, far end clock and sync
    for (int e = 0; e < 2; e++)
    begin
      w = e ? 8'h96 : 8'h4b;
      wr(OFS_CTRL, 32'h1 | (32'(e) << B_RX_FALL));
      u_far.send(w, e[0]);
      repeat (8) @(posedge clk);
      rd(OFS_STAT, d);
      chk("rx valid", 32'h1, d & 32'h1);
      rd(OFS_RXD, d);
      chk("rx word", 32'(w), d);
      $display("test rx edge %0d done", e);
    end
    results();
  end
endmodule
